// ===== core/eetm_pkg.sv
// eetm_pkg: shared constants for the emulator trigger block.
// assumes one clock at 200 MHz; no software-visible registers.
`default_nettype none
package eetm_pkg;
    localparam int CLK_NS = 5;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int STAT_W = 4;
    localparam int CLIP_W = 8;
    localparam int CNT_W = 16;
    localparam int NSTATE = 4;
    localparam int TRACE_DEPTH = 1023;
    localparam int TRACE_W = 48;
    localparam int TIMEOUT_NS = 1000000000;
    localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_NS;
    // condition selector codes for state rules
    localparam logic [2:0] C_ALWAYS = 3'h0;
    localparam logic [2:0] C_MATCH = 3'h1;
    localparam logic [2:0] C_LINK = 3'h2;
    localparam logic [2:0] C_COUNT = 3'h3;
    localparam logic [2:0] C_MATCH_AND_LINK = 3'h4;
    localparam logic [2:0] C_NEVER = 3'h7;
    // per-state rule word: [12] then_break [11:10] then_goto [9] else_break
    // [8:7] else_goto [6] else_stay [5] trace_on [4:2] cond [1] cnt_inc_on_match [0] unused
    localparam int RW = 13;
    localparam int RB_THEN_BRK = 12;
    localparam int RB_THEN_GO = 10;
    localparam int RB_ELSE_BRK = 9;
    localparam int RB_ELSE_GO = 7;
    localparam int RB_ELSE_STAY = 6;
    localparam int RB_TRACE = 5;
    localparam int RB_COND = 2;
    localparam int RB_CNT_INC = 1;
    typedef enum logic [3:0] {
        ST_S0 = 4'h1, ST_S1 = 4'h2, ST_S2 = 4'h4, ST_S3 = 4'h8
    } eetm_state_e;
endpackage
`default_nettype wire

// ===== core/eetm_trace_mem.sv
// eetm_trace_mem: trace frame store, write port plus registered read.
// assumes the caller wraps the write pointer within DEPTH.
`default_nettype none
module eetm_trace_mem
    import eetm_pkg::*;
#(
    parameter int DEPTH = TRACE_DEPTH,
    parameter int WIDTH = TRACE_W,
    parameter int AW = 10
) (
    input wire logic mclk,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge mclk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (ce) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule
`default_nettype wire

// ===== core/eetm_trigger.sv
// eetm_trigger: execution and system event machines, arm window, trace
// qualification, break and bus timeout for an in-circuit emulator.
// assumes all target-side inputs are synchronous to mclk; configuration
// ports are held steady during a run and run_start pulses at emulation start.
// How it works
// - two machines, execution and system, linked through S3
// - execution match on address or range
// - execution starts at first queue byte removal
// - system match on address, data, status, clips
// - four states, each matches, acts, branches
// - S3 occupancy cross-linked to other machine
// - per-machine conditional counter with compare value
// - trace always unless qualification is programmed
// - armed break honoured only inside window
// - window opens on an instruction in the arm range, closes on one outside it or on disarm
// - execution breakpoint list halts emulation
// - system breaks: operand, data, clip, external, coprocessor
// - ranged trace starts at start, stops at stop
// - conditional then/else rules, unconditional branch
// - trace buffer of 1023 frames, 48 bits
// - bus inactivity over one second raises timeout
`default_nettype none
module eetm_trigger
    import eetm_pkg::*;
#(
    parameter int NBRK = 4,
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter int TAW = 10
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic run_start,
    input wire logic queue_first_byte,
    input wire logic [ADDR_W-1:0] exec_addr,
    input wire logic bus_cycle,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_data,
    input wire logic [STAT_W-1:0] bus_status,
    input wire logic [CLIP_W-1:0] clips,
    input wire logic ext_break_req,
    input wire logic coproc_cycle,
    input wire logic [ADDR_W-1:0] xm_lo,
    input wire logic [ADDR_W-1:0] xm_hi,
    input wire logic [ADDR_W-1:0] sm_addr,
    input wire logic [DATA_W-1:0] sm_data,
    input wire logic [DATA_W-1:0] sm_data_mask,
    input wire logic [STAT_W-1:0] sm_status,
    input wire logic [STAT_W-1:0] sm_status_mask,
    input wire logic [CLIP_W-1:0] sm_clips,
    input wire logic [CLIP_W-1:0] sm_clips_mask,
    input wire logic sm_use_addr,
    input wire logic [NSTATE*RW-1:0] xm_rules,
    input wire logic [NSTATE*RW-1:0] sm_rules,
    input wire logic [CNT_W-1:0] xm_cnt_cmp,
    input wire logic [CNT_W-1:0] sm_cnt_cmp,
    input wire logic [NBRK*ADDR_W-1:0] brk_addrs,
    input wire logic [NBRK-1:0] brk_valid,
    input wire logic sys_brk_en,
    input wire logic ext_brk_en,
    input wire logic coproc_brk_en,
    input wire logic arm_en,
    input wire logic [ADDR_W-1:0] arm_lo,
    input wire logic [ADDR_W-1:0] arm_hi,
    input wire logic trace_qual_en,
    input wire logic trace_use_machines,
    input wire logic [ADDR_W-1:0] trace_start_addr,
    input wire logic [ADDR_W-1:0] trace_stop_addr,
    input wire logic bus_inactive_timeout_enable,
    input wire logic [TAW-1:0] trace_rd_addr,
    output logic [TRACE_W-1:0] trace_rd_data,
    output logic break_out,
    output logic trace_active,
    output logic timeout_out,
    output logic arm_window,
    output logic [3:0] xm_state_out,
    output logic [3:0] sm_state_out,
    output logic [TAW-1:0] trace_wr_ptr
);
    eetm_state_e xm_state_reg, sm_state_reg;
    eetm_state_e xm_state_next, sm_state_next;
    logic [CNT_W-1:0] xm_cnt_reg, sm_cnt_reg;
    logic xm_match, sm_match, xm_brk, sm_brk, xm_trc, sm_trc;
    logic cross_machine_link_x, cross_machine_link_s;
    logic exec_brk_hit, sys_hit, armed_hit, trace_range_reg, trace_range_now, trace_now;
    logic [31:0] idle_cnt_reg;
    logic [NBRK-1:0] brk_hit_vec;

    assign xm_match = queue_first_byte && exec_addr >= xm_lo && exec_addr <= xm_hi;
    assign sm_match = bus_cycle && (!sm_use_addr || bus_addr == sm_addr)
        && ((bus_data & sm_data_mask) == (sm_data & sm_data_mask))
        && ((bus_status & sm_status_mask) == (sm_status & sm_status_mask))
        && ((clips & sm_clips_mask) == (sm_clips & sm_clips_mask));
    assign cross_machine_link_x = (sm_state_reg == ST_S3);
    assign cross_machine_link_s = (xm_state_reg == ST_S3);

    function automatic logic cond_eval(input logic [2:0] c, input logic m, input logic l,
                                       input logic k);
        case (c)
            C_ALWAYS: cond_eval = 1'b1;
            C_MATCH: cond_eval = m;
            C_LINK: cond_eval = l;
            C_COUNT: cond_eval = k;
            C_MATCH_AND_LINK: cond_eval = m && l;
            default: cond_eval = 1'b0;
        endcase
    endfunction

    function automatic int st_idx(input eetm_state_e s);
        case (s)
            ST_S0: st_idx = 0;
            ST_S1: st_idx = 1;
            ST_S2: st_idx = 2;
            ST_S3: st_idx = 3;
            default: st_idx = 0;
        endcase
    endfunction

    function automatic eetm_state_e st_of(input logic [1:0] i);
        case (i)
            2'h0: st_of = ST_S0;
            2'h1: st_of = ST_S1;
            2'h2: st_of = ST_S2;
            default: st_of = ST_S3;
        endcase
    endfunction

    // one evaluation per machine: then/else actions or unconditional branch
    always_comb begin
        logic [RW-1:0] r;
        logic hit;
        r = xm_rules[st_idx(xm_state_reg)*RW +: RW];
        hit = cond_eval(r[RB_COND +: 3], xm_match, cross_machine_link_x,
                        xm_cnt_reg == xm_cnt_cmp);
        xm_brk = hit ? r[RB_THEN_BRK] : r[RB_ELSE_BRK];
        xm_trc = r[RB_TRACE];
        if (hit) begin
            xm_state_next = st_of(r[RB_THEN_GO +: 2]);
        end else if (r[RB_ELSE_STAY]) begin
            xm_state_next = xm_state_reg;
        end else begin
            xm_state_next = st_of(r[RB_ELSE_GO +: 2]);
        end
    end

    always_comb begin
        logic [RW-1:0] r;
        logic hit;
        r = sm_rules[st_idx(sm_state_reg)*RW +: RW];
        hit = cond_eval(r[RB_COND +: 3], sm_match, cross_machine_link_s,
                        sm_cnt_reg == sm_cnt_cmp);
        sm_brk = hit ? r[RB_THEN_BRK] : r[RB_ELSE_BRK];
        sm_trc = r[RB_TRACE];
        if (hit) begin
            sm_state_next = st_of(r[RB_THEN_GO +: 2]);
        end else if (r[RB_ELSE_STAY]) begin
            sm_state_next = sm_state_reg;
        end else begin
            sm_state_next = st_of(r[RB_ELSE_GO +: 2]);
        end
    end

    // machines are cross-linked through S3 occupancy; each advances on every enabled cycle except a run start
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            xm_state_reg <= ST_S0;
            sm_state_reg <= ST_S0;
        end else if (ce) begin
            if (run_start) begin
                xm_state_reg <= ST_S0;
                sm_state_reg <= ST_S0;
            end else begin
                xm_state_reg <= xm_state_next;
                sm_state_reg <= sm_state_next;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            xm_cnt_reg <= '0;
            sm_cnt_reg <= '0;
        end else if (ce) begin
            if (run_start) begin
                xm_cnt_reg <= '0;
                sm_cnt_reg <= '0;
            end else begin
                if (xm_rules[st_idx(xm_state_reg)*RW + RB_CNT_INC] && xm_match) begin
                    xm_cnt_reg <= xm_cnt_reg + 1'b1;
                end
                if (sm_rules[st_idx(sm_state_reg)*RW + RB_CNT_INC] && sm_match) begin
                    sm_cnt_reg <= sm_cnt_reg + 1'b1;
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NBRK; g++) begin : g_brk
            assign brk_hit_vec[g] = brk_valid[g]
                && exec_addr == brk_addrs[g*ADDR_W +: ADDR_W];
        end
    endgenerate
    assign exec_brk_hit = queue_first_byte && |brk_hit_vec;
    assign sys_hit = (sys_brk_en && sm_match) || (ext_brk_en && ext_break_req)
        || (coproc_brk_en && coproc_cycle);
    // when arming is enabled the system trigger is the armed breakpoint
    assign armed_hit = arm_en ? (arm_window && sys_hit) : sys_hit;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            arm_window <= 1'b0;
        end else if (ce) begin
            if (run_start || !arm_en) begin
                arm_window <= 1'b0;
            end else if (queue_first_byte) begin
                arm_window <= exec_addr >= arm_lo && exec_addr <= arm_hi;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            break_out <= 1'b0;
        end else if (ce) begin
            break_out <= !run_start && (exec_brk_hit || armed_hit || xm_brk || sm_brk);
        end
    end

    // stop wins when start and stop addresses coincide; the start instruction
    // itself lands in the buffer, the stop instruction does not
    assign trace_range_now = (queue_first_byte && exec_addr == trace_stop_addr) ? 1'b0
        : (queue_first_byte && exec_addr == trace_start_addr) ? 1'b1 : trace_range_reg;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            trace_range_reg <= 1'b0;
        end else if (ce) begin
            if (run_start) begin
                trace_range_reg <= 1'b0;
            end else begin
                trace_range_reg <= trace_range_now;
            end
        end
    end

    assign trace_now = !trace_qual_en ? 1'b1
        : (trace_use_machines ? (xm_trc || sm_trc) : trace_range_now);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            trace_active <= 1'b0;
            trace_wr_ptr <= '0;
        end else if (ce) begin
            trace_active <= trace_now;
            if (run_start) begin
                trace_wr_ptr <= '0;
            end else if (trace_now && (queue_first_byte || bus_cycle)) begin
                trace_wr_ptr <= (trace_wr_ptr == TAW'(TRACE_DEPTH - 1)) ? '0
                    : trace_wr_ptr + 1'b1;
            end
        end
    end

    eetm_trace_mem #(.DEPTH(TRACE_DEPTH), .WIDTH(TRACE_W), .AW(TAW)) u_mem (
        .mclk(mclk),
        .ce(ce),
        .wr_en(trace_now && (queue_first_byte || bus_cycle) && !run_start),
        .wr_addr(trace_wr_ptr),
        .wr_data({bus_cycle, queue_first_byte, bus_status[1:0],
                  bus_cycle ? bus_addr : exec_addr, bus_data, clips}),
        .rd_addr(trace_rd_addr),
        .rd_data(trace_rd_data)
    );

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            idle_cnt_reg <= '0;
            timeout_out <= 1'b0;
        end else if (ce) begin
            if (run_start || bus_cycle || !bus_inactive_timeout_enable) begin
                idle_cnt_reg <= '0;
                timeout_out <= 1'b0;
            end else if (idle_cnt_reg >= 32'(TIMEOUT_CYCLES)) begin
                timeout_out <= 1'b1;
            end else begin
                idle_cnt_reg <= idle_cnt_reg + 32'h1;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            xm_state_out <= ST_S0;
            sm_state_out <= ST_S0;
        end else if (ce) begin
            // mirrors the state registers, run start included
            xm_state_out <= run_start ? ST_S0 : xm_state_next;
            sm_state_out <= run_start ? ST_S0 : sm_state_next;
        end
    end
endmodule
`default_nettype wire

// ===== verif/eetm_trigger_properties.sv
// eetm_trigger_properties: port checks for the trigger block.
// assumes it is bound to eetm_trigger and sees only that module's ports.
`default_nettype none
module eetm_chk
    import eetm_pkg::*;
#(
    parameter int NBRK = 4,
    parameter int TAW = 10
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic run_start,
    input wire logic queue_first_byte,
    input wire logic [ADDR_W-1:0] exec_addr,
    input wire logic bus_cycle,
    input wire logic [NBRK*ADDR_W-1:0] brk_addrs,
    input wire logic [NBRK-1:0] brk_valid,
    input wire logic arm_en,
    input wire logic [ADDR_W-1:0] arm_lo,
    input wire logic [ADDR_W-1:0] arm_hi,
    input wire logic trace_qual_en,
    input wire logic trace_use_machines,
    input wire logic [ADDR_W-1:0] trace_stop_addr,
    input wire logic bus_inactive_timeout_enable,
    input wire logic break_out,
    input wire logic trace_active,
    input wire logic timeout_out,
    input wire logic arm_window,
    input wire logic [3:0] xm_state_out,
    input wire logic [3:0] sm_state_out,
    input wire logic [TAW-1:0] trace_wr_ptr
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    // run_start wins over any instruction taken on the same edge
    wire qf = ce && queue_first_byte && !run_start;
    wire in_arm = exec_addr >= arm_lo && exec_addr <= arm_hi;
    exec_brk_a: assert property (
        qf && brk_valid[0] && exec_addr == brk_addrs[ADDR_W-1:0] |=> break_out)
        else $error("listed instruction did not break");
    run_clear_a: assert property (
        ce && run_start |=> xm_state_out == 4'h1 && sm_state_out == 4'h1 && !arm_window
        && trace_wr_ptr == '0 && !timeout_out) else $error("run start left state behind");
    freeze_a: assert property (
        !ce |=> $stable(xm_state_out) && $stable(sm_state_out) && $stable(trace_wr_ptr))
        else $error("state moved with enable low");
    state_hot_a: assert property (
        $onehot(xm_state_out) && $onehot(sm_state_out)) else $error("state not one of four");
    arm_open_a: assert property (
        qf && arm_en && in_arm |=> arm_window) else $error("arm window did not open");
    arm_close_a: assert property (
        qf && arm_en && !in_arm |=> !arm_window) else $error("arm window did not close");
    trace_free_a: assert property (
        ce && !run_start && !trace_qual_en |=> trace_active) else $error("trace not free");
    trace_stop_a: assert property (
        qf && trace_qual_en && !trace_use_machines && exec_addr == trace_stop_addr
        |=> !trace_active) else $error("trace ran past stop address");
    tmo_clear_a: assert property (
        ce && (bus_cycle || !bus_inactive_timeout_enable) |=> !timeout_out)
        else $error("timeout with bus active or disabled");
    cover property (break_out);
    cover property (timeout_out);
    cover property (arm_window && break_out);
endmodule
bind eetm_trigger eetm_chk #(.NBRK(NBRK), .TAW(TAW)) chk (.*);
`default_nettype wire

// ===== verif/eetm_cpu_model.sv
// eetm_cpu_model: target processor queue and bus as the trigger sees them.
// assumes each task is entered right after a rising edge of mclk.
`default_nettype none
module eetm_cpu_model
    import eetm_pkg::*;
(
    input wire logic mclk,
    output logic queue_first_byte,
    output logic [ADDR_W-1:0] exec_addr,
    output logic bus_cycle,
    output logic [ADDR_W-1:0] bus_addr,
    output logic [DATA_W-1:0] bus_data,
    output logic [STAT_W-1:0] bus_status,
    output logic [CLIP_W-1:0] clips
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        queue_first_byte = 1'b0;
        bus_cycle = 1'b0;
        {exec_addr, bus_addr, bus_data, bus_status, clips} = '0;
    end
    // pulse only when the first byte leaves the queue; prefetch stays invisible
    task automatic exec_at(input logic [ADDR_W-1:0] a);
        queue_first_byte <= 1'b1;
        exec_addr <= a;
        @(posedge mclk);
        queue_first_byte <= 1'b0;
        exec_addr <= ~a;
    endtask
    // lines go inverted outside a cycle so a stale value can never match
    task automatic bus_at(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
        input logic [STAT_W-1:0] s, input logic [CLIP_W-1:0] c);
        bus_cycle <= 1'b1;
        {bus_addr, bus_data, bus_status, clips} <= {a, d, s, c};
        @(posedge mclk);
        bus_cycle <= 1'b0;
        {bus_addr, bus_data, bus_status, clips} <= ~{a, d, s, c};
    endtask
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// tb_top: self-checking bench for eetm_trigger driven by a target model.
// assumes a short timeout parameter so the idle test stays brief.
`default_nettype none
module tb_top
    import eetm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
`define CHK(n, e, g) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("BAD %s exp %h got %h", n, e, g); \
    end \
end
    int err_count = 0;
    int cmp_count = 0;
    logic mclk, reset, ce, run_start, ext_break_req, coproc_cycle, sm_use_addr, sys_brk_en;
    logic queue_first_byte, bus_cycle, ext_brk_en, coproc_brk_en, arm_en, trace_qual_en;
    logic trace_use_machines, bus_inactive_timeout_enable;
    logic break_out, trace_active, timeout_out, arm_window;
    logic [ADDR_W-1:0] exec_addr, bus_addr, xm_lo, xm_hi, sm_addr, arm_lo, arm_hi;
    logic [ADDR_W-1:0] trace_start_addr, trace_stop_addr;
    logic [DATA_W-1:0] bus_data, sm_data, sm_data_mask;
    logic [STAT_W-1:0] bus_status, sm_status, sm_status_mask;
    logic [CLIP_W-1:0] clips, sm_clips, sm_clips_mask;
    logic [NSTATE*RW-1:0] xm_rules, sm_rules;
    logic [CNT_W-1:0] xm_cnt_cmp, sm_cnt_cmp;
    logic [4*ADDR_W-1:0] brk_addrs;
    logic [3:0] brk_valid, xm_state_out, sm_state_out;
    logic [9:0] trace_rd_addr, trace_wr_ptr, p;
    logic [TRACE_W-1:0] trace_rd_data;
    typedef struct {logic [ADDR_W-1:0] a; logic x; logic c; logic b;} eetm_row_s;
    eetm_row_s rows[8] = '{'{20'h00100, 1'b0, 1'b0, 1'b1}, '{20'h00200, 1'b0, 1'b0, 1'b1},
        '{20'h00300, 1'b0, 1'b0, 1'b1}, '{20'h00400, 1'b0, 1'b0, 1'b0},
        '{20'h00101, 1'b0, 1'b0, 1'b0}, '{20'h00000, 1'b1, 1'b0, 1'b1},
        '{20'h00000, 1'b0, 1'b1, 1'b1}, '{20'h000FF, 1'b0, 1'b0, 1'b0}};
    eetm_trigger #(.TIMEOUT_CYCLES(20)) dut (.*);
    eetm_cpu_model cpu (.*);
    always #2.5 mclk = ~mclk;
    task automatic summarize;
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic start;
        @(posedge mclk);
        run_start <= 1'b1;
        @(posedge mclk);
        run_start <= 1'b0;
    endtask
    task automatic ex(input logic [ADDR_W-1:0] a);
        @(posedge mclk);
        cpu.exec_at(a);
        #1;
    endtask
    task automatic bs;
        @(posedge mclk);
        cpu.bus_at(sm_addr, sm_data, sm_status, sm_clips);
        #1;
    endtask
    task automatic wait_sm(input logic [3:0] s);
        for (int i = 0; i < 8 && sm_state_out !== s; i++) @(posedge mclk);
        #1;
    endtask
    initial begin
        {mclk, run_start, ext_break_req, coproc_cycle, sys_brk_en, arm_en} = '0;
        {trace_qual_en, trace_use_machines, bus_inactive_timeout_enable} = '0;
        {xm_lo, xm_hi, arm_lo, arm_hi, trace_start_addr, trace_stop_addr} = '0;
        {sm_data_mask, sm_status_mask, sm_clips_mask, xm_cnt_cmp, trace_rd_addr} = '0;
        {ce, sm_use_addr, ext_brk_en, coproc_brk_en, sm_cnt_cmp} = {4'hF, 16'h0003};
        {sm_addr, sm_data, sm_status, sm_clips} = {20'h00A00, 16'h1234, 4'h5, 8'hC3};
        brk_addrs = {20'h00400, 20'h00300, 20'h00200, 20'h00100};
        brk_valid = 4'h7;
        xm_rules = {4{13'h005C}};
        sm_rules = {4{13'h005C}};
        reset = 1'b1;
        repeat (12) @(posedge mclk);
        `CHK("xm reset", 4'h1, xm_state_out)
        reset <= 1'b0;
        start;
        foreach (rows[i]) begin
            @(posedge mclk);
            {ext_break_req, coproc_cycle} <= {rows[i].x, rows[i].c};
            cpu.exec_at(rows[i].a);
            {ext_break_req, coproc_cycle} <= 2'b00;
            #1;
            `CHK("break", rows[i].b, break_out)
        end
        @(posedge mclk);
        {arm_lo, arm_hi, arm_en, sys_brk_en} <= {20'h00800, 20'h008FF, 2'b11};
        bs;
        `CHK("closed brk", 1'b0, break_out)
        ex(20'h00810);
        `CHK("arm open", 1'b1, arm_window)
        bs;
        `CHK("armed brk", 1'b1, break_out)
        ex(20'h00900);
        `CHK("arm close", 1'b0, arm_window)
        @(posedge mclk);
        {arm_en, sys_brk_en} <= 2'b00;
        p = trace_wr_ptr;
        ex(20'h00123);
        `CHK("trace on", 1'b1, trace_active)
        `CHK("wr ptr", p + 10'h001, trace_wr_ptr)
        @(posedge mclk);
        trace_rd_addr <= p;
        @(posedge mclk);
        #1;
        `CHK("frame", {2'b01, 20'h00123}, {trace_rd_data[47:46], trace_rd_data[43:24]})
        @(posedge mclk);
        ce <= 1'b0;
        p = trace_wr_ptr;
        ex(20'h00124);
        `CHK("frozen", p, trace_wr_ptr)
        @(posedge mclk);
        ce <= 1'b1;
        {trace_qual_en, trace_start_addr, trace_stop_addr} <= {1'b1, 20'h00C00, 20'h00D00};
        ex(20'h00555);
        `CHK("trace idle", 1'b0, trace_active)
        ex(20'h00C00);
        `CHK("trace start", 1'b1, trace_active)
        ex(20'h00C80);
        `CHK("trace hold", 1'b1, trace_active)
        ex(20'h00D00);
        `CHK("trace stop", 1'b0, trace_active)
        @(posedge mclk);
        {xm_lo, xm_hi} <= {20'h00E00, 20'h00E00};
        xm_rules <= {13'h0C00, 13'h005C, 13'h005C, 13'h0C04};
        sm_rules <= {13'h005C, 13'h005C, 13'h084E, 13'h1448};
        start;
        bs;
        `CHK("no link", 4'h1, sm_state_out)
        ex(20'h00E00);
        wait_sm(4'h2);
        `CHK("xm S3", 4'h8, xm_state_out)
        `CHK("link", 4'h2, sm_state_out)
        repeat (2) bs;
        `CHK("count 2", 4'h2, sm_state_out)
        bs;
        wait_sm(4'h4);
        `CHK("count 3", 4'h4, sm_state_out)
        @(posedge mclk);
        bus_inactive_timeout_enable <= 1'b1;
        start;
        repeat (10) @(posedge mclk);
        #1;
        `CHK("tmo early", 1'b0, timeout_out)
        repeat (20) @(posedge mclk);
        #1;
        `CHK("tmo", 1'b1, timeout_out)
        bs;
        `CHK("tmo clear", 1'b0, timeout_out)
        summarize;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        summarize;
    end
endmodule
`default_nettype wire
